// *** common/buck_ctrl_pkg.sv ***
package buck_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_MODE   = 8'h04;
    localparam logic [7:0] OFF_CFG    = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_IRQ    = 8'h10;
    localparam logic [7:0] OFF_MASK   = 8'h14;
    localparam logic [7:0] OFF_MVOLT  = 8'h18;

    // ==========================================================
    // Field positions
    localparam int VCODE_LSB  = 0;
    localparam int RUN_LSB    = 0;
    localparam int STBY_LSB   = 2;
    localparam int ILIM_LSB   = 0;
    localparam int PHASE_LSB  = 2;
    localparam int IRQ_MODE_B = 0;
    localparam int IRQ_VDONE_B = 1;

    // ==========================================================
    // Reset values
    localparam logic [2:0] PHASE_RST = 3'h7;
    localparam logic [1:0] ILIM_RST  = 2'h0;
    localparam logic [1:0] IRQ_RST   = 2'h0;

    // ==========================================================
    // Timing
    localparam int CLK_MHZ      = 20;
    localparam int T_PFM_PWM_US = 10;
    localparam int T_RAMP_MIN_US = 90;
    localparam int T_RAMP_MAX_US = 200;
    localparam int T_ON_MIN_US  = 100;
    localparam int T_ON_TYP_US  = 180;
    localparam int T_ON_MAX_US  = 300;
    localparam int PFM_PWM_CYC  = T_PFM_PWM_US * CLK_MHZ;
    localparam int RAMP_CYC     = T_RAMP_MIN_US * CLK_MHZ;
    localparam int TON_CYC      = T_ON_TYP_US * CLK_MHZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        MODE_OFF  = 2'h0,
        MODE_PWM  = 2'h1,
        MODE_PFM  = 2'h2,
        MODE_AUTO = 2'h3
    } buck_mode_field_t;

    typedef enum logic [3:0] {
        ST_OFF   = 4'h1,
        ST_RAMP  = 4'h2,
        ST_ON    = 4'h4,
        ST_DISCH = 4'h8
    } seq_state_t;

    typedef struct packed {
        logic [4:0]       buck_voltage_code;
        buck_mode_field_t buck_mode_field;
        logic [1:0]       buck_current_limit_sel;
        logic [2:0]       buck_phase_sel;
    } buck_cfg_t;

endpackage : buck_ctrl_pkg

// *** hdl/low_voltage_buck_ctrl.sv ***
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - One 5-bit voltage code for Run and Standby
// - New code while on: discharge, then re-enable
// - Voltage code defaults from OTP at power up
// - Fixed 32-entry voltage table, codes 27-31 4.10V
// - Run mode resets autoskip if sequenced, else off
// - Standby mode resets autoskip if sequenced, else off
// - Mode 00 off, 01 PWM, 10 PFM, 11 autoskip
// - Mode change raises maskable interrupt on pin
// - Run-to-Standby keeps voltage unless enable changes
// - Current limit select 2.1/2.6/3.0/4.5 A
// - Phase code steps 45 degrees, 111 is zero
// - Phase defaults zero, writable while on
// - OTP inductor select, code 11 reserved
// - PFM-to-PWM settles after at least 10 us
// - Soft-start ramp 90 to 200 us
// - Turn-on reaches 90 percent in 100-300 us
module low_voltage_buck_ctrl #(
    parameter int PFM_PWM_CYCLES = buck_ctrl_pkg::PFM_PWM_CYC,
    parameter int RAMP_CYCLES    = buck_ctrl_pkg::RAMP_CYC,
    parameter int TON_CYCLES     = buck_ctrl_pkg::TON_CYC
) (
    input  wire logic        hclk,                 // Bus clock
    input  wire logic        hresetn,              // Async reset, low
    input  wire logic        hsel,                 // Slave select
    input  wire logic [31:0] haddr,                // Address
    input  wire logic [1:0]  htrans,               // Transfer type
    input  wire logic        hwrite,               // Write
    input  wire logic [2:0]  hsize,                // Size
    input  wire logic [31:0] hwdata,               // Write data
    input  wire logic        hready,               // Bus ready in
    output logic      [31:0] hrdata,               // Read data
    output logic             hreadyout,            // Slave ready
    output logic             hresp,                // Response
    input  wire logic [4:0]  otp_buck_voltage_default, // OTP code
    input  wire logic [1:0]  otp_inductor_sel,     // OTP inductor
    input  wire logic        otp_in_powerup_seq,   // OTP sequenced
    input  wire logic        standby_req,          // Standby state
    output logic             buck_enable,          // Power stage on
    output logic             buck_discharge,       // Output pulldown
    output logic             buck_ramping,         // Ramp-up or discharge active
    output logic             buck_power_good,      // Output settled
    output logic             mode_settled,         // Mode settled
    output buck_ctrl_pkg::buck_cfg_t buck_cfg,     // Active settings
    output logic [8:0]       buck_phase_deg,       // Phase in degrees
    output logic [9:0]       buck_ilim_da,         // Limit, 0.1 A
    output logic [8:0]       buck_mv_10,           // Volts x100
    output logic             inductor_sel_invalid, // Reserved OTP
    output logic             irq_out_n             // Interrupt, low
);

    // ==========================================================
    // Lookup functions
    function automatic logic [8:0] volt_of(input logic [4:0] c);
        logic [8:0] v;
        v = 9'd410;
        case (c)
            5'h00: v = 9'd100;  5'h01: v = 9'd110;
            5'h02: v = 9'd120;  5'h03: v = 9'd125;
            5'h04: v = 9'd130;  5'h05: v = 9'd135;
            5'h06: v = 9'd150;  5'h07: v = 9'd160;
            5'h08: v = 9'd180;  5'h09: v = 9'd185;
            5'h0a: v = 9'd200;  5'h0b: v = 9'd210;
            5'h0c: v = 9'd215;  5'h0d: v = 9'd225;
            5'h0e: v = 9'd230;  5'h0f: v = 9'd240;
            5'h10: v = 9'd250;  5'h11: v = 9'd280;
            5'h12: v = 9'd315;  5'h13: v = 9'd320;
            5'h14: v = 9'd325;  5'h15: v = 9'd330;
            5'h16: v = 9'd335;  5'h17: v = 9'd340;
            5'h18: v = 9'd350;  5'h19: v = 9'd380;
            5'h1a: v = 9'd400;
            default: v = 9'd410;
        endcase
        return v;
    endfunction : volt_of

    // ==========================================================
    // Bus address phase capture
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [7:0]  addr_q;
    logic        init_q;

    logic [4:0]  vcode_q;
    logic [1:0]  run_mode_q;
    logic [1:0]  stby_mode_q;
    logic [1:0]  ilim_q;
    logic [2:0]  phase_q;
    logic [1:0]  irq_q;
    logic [1:0]  mask_q;
    logic        resync_q;

    wire access = hsel & hready & htrans[1];
    wire wr_en  = wr_pend_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= access & hwrite;
            rd_pend_q <= access & ~hwrite;
            addr_q    <= haddr[7:0];
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    wire wr_ctrl = wr_en & (addr_q == buck_ctrl_pkg::OFF_CTRL);
    wire wr_mode = wr_en & (addr_q == buck_ctrl_pkg::OFF_MODE);
    wire wr_cfg  = wr_en & (addr_q == buck_ctrl_pkg::OFF_CFG);
    wire wr_irq  = wr_en & (addr_q == buck_ctrl_pkg::OFF_IRQ);
    wire wr_mask = wr_en & (addr_q == buck_ctrl_pkg::OFF_MASK);

    // ==========================================================
    // Sequencer
    buck_ctrl_pkg::seq_state_t state_q;
    buck_ctrl_pkg::seq_state_t state_d;
    logic [15:0] tmr_q;
    logic [15:0] settle_q;
    logic [1:0]  eff_mode_q;

    // Both states share one code; standby only picks the mode field
    wire [1:0] want_mode =
        standby_req ? stby_mode_q : run_mode_q;
    wire       want_on   = (want_mode != buck_ctrl_pkg::MODE_OFF);
    wire       tmr_done  = (tmr_q == 16'h0000);
    // Rewriting the same code leaves the output alone
    wire       new_code  = wr_ctrl & (hwdata[4:0] != vcode_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            buck_ctrl_pkg::ST_OFF:
                if (want_on & init_q) state_d = buck_ctrl_pkg::ST_RAMP;
            buck_ctrl_pkg::ST_RAMP:
                if (!want_on) state_d = buck_ctrl_pkg::ST_DISCH;
                else if (resync_q) state_d = buck_ctrl_pkg::ST_DISCH;
                else if (tmr_done) state_d = buck_ctrl_pkg::ST_ON;
            buck_ctrl_pkg::ST_ON:
                if (!want_on | resync_q)
                    state_d = buck_ctrl_pkg::ST_DISCH;
            buck_ctrl_pkg::ST_DISCH:
                if (tmr_done) state_d = buck_ctrl_pkg::ST_OFF;
            default: state_d = buck_ctrl_pkg::ST_OFF;
        endcase
    end

    wire entering = (state_d != state_q);

    // One timer serves ramp-up and discharge, which never overlap
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= buck_ctrl_pkg::ST_OFF;
            tmr_q   <= 16'h0000;
        end else begin
            state_q <= state_d;
            if (entering && state_d == buck_ctrl_pkg::ST_RAMP)
                tmr_q <= 16'(TON_CYCLES - 1);
            else if (entering && state_d == buck_ctrl_pkg::ST_DISCH)
                tmr_q <= 16'(RAMP_CYCLES - 1);
            else if (!tmr_done)
                tmr_q <= tmr_q - 16'h0001;
        end
    end

    // Resequence request is held until the discharge has started,
    // so a code write during ramp-up is not lost.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resync_q <= 1'b0;
        end else if (new_code && state_q != buck_ctrl_pkg::ST_OFF) begin
            resync_q <= 1'b1;
        end else if (state_q == buck_ctrl_pkg::ST_DISCH) begin
            resync_q <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers; OTP straps caught one cycle after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            init_q      <= 1'b0;
            vcode_q     <= 5'h00;
            run_mode_q  <= buck_ctrl_pkg::MODE_OFF;
            stby_mode_q <= buck_ctrl_pkg::MODE_OFF;
            ilim_q      <= buck_ctrl_pkg::ILIM_RST;
            phase_q     <= buck_ctrl_pkg::PHASE_RST;
        end else if (!init_q) begin
            init_q      <= 1'b1;
            vcode_q     <= otp_buck_voltage_default;
            run_mode_q  <= otp_in_powerup_seq ? buck_ctrl_pkg::MODE_AUTO
                : buck_ctrl_pkg::MODE_OFF;
            stby_mode_q <= otp_in_powerup_seq ? buck_ctrl_pkg::MODE_AUTO
                : buck_ctrl_pkg::MODE_OFF;
        end else begin
            if (wr_ctrl) vcode_q <= hwdata[4:0];
            if (wr_mode) begin
                run_mode_q  <= hwdata[buck_ctrl_pkg::RUN_LSB +: 2];
                stby_mode_q <= hwdata[buck_ctrl_pkg::STBY_LSB +: 2];
            end
            if (wr_cfg) begin
                ilim_q  <= hwdata[buck_ctrl_pkg::ILIM_LSB +: 2];
                phase_q <= hwdata[buck_ctrl_pkg::PHASE_LSB +: 3];
            end
        end
    end

    // ==========================================================
    // Operating mode tracking and settle timer
    wire [1:0] act_mode = (state_q == buck_ctrl_pkg::ST_ON ||
                           state_q == buck_ctrl_pkg::ST_RAMP) ?
                          want_mode : buck_ctrl_pkg::MODE_OFF;
    wire mode_chg = (act_mode != eff_mode_q);
    // PWM entered from PFM or autoskip needs time before it counts
    wire to_pwm   = mode_chg & (act_mode == buck_ctrl_pkg::MODE_PWM) &
                    (eff_mode_q != buck_ctrl_pkg::MODE_OFF);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eff_mode_q <= buck_ctrl_pkg::MODE_OFF;
            settle_q   <= 16'h0000;
        end else begin
            eff_mode_q <= act_mode;
            if (to_pwm)
                settle_q <= 16'(PFM_PWM_CYCLES);
            else if (settle_q != 16'h0000)
                settle_q <= settle_q - 16'h0001;
        end
    end

    // ==========================================================
    // Interrupts: set wins over write-one-to-clear
    wire [1:0] irq_set;
    assign irq_set[buck_ctrl_pkg::IRQ_MODE_B]  = mode_chg;
    assign irq_set[buck_ctrl_pkg::IRQ_VDONE_B] =
        entering & (state_d == buck_ctrl_pkg::ST_ON);
    wire [1:0] irq_clr = wr_irq ? hwdata[1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q  <= buck_ctrl_pkg::IRQ_RST;
            mask_q <= 2'h3;
        end else begin
            irq_q <= (irq_q & ~irq_clr) | irq_set;
            if (wr_mask) mask_q <= hwdata[1:0];
        end
    end

    // Mask gates only the pin; the flag still records
    assign irq_out_n = ~|(irq_q & ~mask_q);

    // ==========================================================
    // Read mux
    // Status packs settled, OTP inductor, mode and state
    wire [31:0] status_w = {22'h0, settle_q == 16'h0000,
                            inductor_sel_invalid, otp_inductor_sel,
                            eff_mode_q, state_q};
    logic [31:0] rd_mux;
    always_comb begin
        case (addr_q)
            buck_ctrl_pkg::OFF_CTRL:   rd_mux = {27'h0, vcode_q};
            buck_ctrl_pkg::OFF_MODE: rd_mux = {28'h0, stby_mode_q, run_mode_q};
            buck_ctrl_pkg::OFF_CFG:    rd_mux = {27'h0, phase_q, ilim_q};
            buck_ctrl_pkg::OFF_STATUS: rd_mux = status_w;
            buck_ctrl_pkg::OFF_IRQ:    rd_mux = {30'h0, irq_q};
            buck_ctrl_pkg::OFF_MASK:   rd_mux = {30'h0, mask_q};
            buck_ctrl_pkg::OFF_MVOLT:  rd_mux = {23'h0, volt_of(vcode_q)};
            default:                   rd_mux = 32'h0;
        endcase
    end
    assign hrdata = rd_pend_q ? rd_mux : 32'h0;

    // ==========================================================
    // Power stage outputs
    assign buck_enable    = (state_q == buck_ctrl_pkg::ST_RAMP) |
                            (state_q == buck_ctrl_pkg::ST_ON);
    assign buck_ramping   = (state_q == buck_ctrl_pkg::ST_RAMP) |
                            (state_q == buck_ctrl_pkg::ST_DISCH);
    assign buck_discharge = (state_q == buck_ctrl_pkg::ST_DISCH) |
                            (state_q == buck_ctrl_pkg::ST_OFF);
    assign buck_power_good = (state_q == buck_ctrl_pkg::ST_ON);
    assign mode_settled   = (settle_q == 16'h0000);
    assign inductor_sel_invalid = (otp_inductor_sel == 2'h3);

    assign buck_cfg.buck_voltage_code      = vcode_q;
    assign buck_cfg.buck_mode_field        =
        buck_ctrl_pkg::buck_mode_field_t'(eff_mode_q);
    assign buck_cfg.buck_current_limit_sel = ilim_q;
    assign buck_cfg.buck_phase_sel         = phase_q;

    // 000 is 45 degrees, 111 wraps to 0
    wire [8:0] ph_ext = {6'h00, phase_q} + 9'h001;
    assign buck_phase_deg = (phase_q == 3'h7) ? 9'h000
                          : 9'(ph_ext * 9'd45);
    assign buck_ilim_da = (ilim_q == 2'h0) ? 10'd21 :
                          (ilim_q == 2'h1) ? 10'd26 :
                          (ilim_q == 2'h2) ? 10'd30 : 10'd45;
    assign buck_mv_10 = volt_of(vcode_q);

endmodule : low_voltage_buck_ctrl

// *** verification/buck_ctrl_sva.sv ***
`timescale 1ns/1ps
module buck_ctrl_sva #(
    parameter int TON_CYCLES = buck_ctrl_pkg::TON_CYC
) (
    input wire logic                     hclk,            // Clock
    input wire logic                     hresetn,         // Reset, low
    input wire logic                     hsel,            // Select
    input wire logic [1:0]               htrans,          // Transfer
    input wire logic                     hwrite,          // Write
    input wire logic                     hready,          // Ready in
    input wire logic                     standby_req,     // Standby
    input wire logic                     buck_enable,     // Stage on
    input wire logic                     buck_discharge,  // Pulldown
    input wire logic                     buck_ramping,    // Ramp
    input wire logic                     buck_power_good, // Up
    input wire logic                     mode_settled,    // Mode ok
    input wire buck_ctrl_pkg::buck_cfg_t buck_cfg,        // Settings
    input wire logic [8:0]               buck_phase_deg,  // Degrees
    input wire logic [9:0]               buck_ilim_da,    // Limit
    input wire logic [8:0]               buck_mv_10,      // Volts
    input wire logic                     irq_out_n        // Interrupt
);
    // ==========================================================
    // Expected decodes
    logic [15:0] on_cnt_q;
    logic [15:0] on_cnt_d;
    logic [1:0]  ilim_sel;
    logic [2:0]  ph_sel;
    logic [9:0]  ilim_exp;
    logic [8:0]  deg_exp;
    assign ilim_sel = buck_cfg.buck_current_limit_sel;
    assign ph_sel   = buck_cfg.buck_phase_sel;
    assign ilim_exp = ilim_sel == 2'h0 ? 10'h015 : ilim_sel == 2'h1 ? 10'h01a
                    : ilim_sel == 2'h2 ? 10'h01e : 10'h02d;
    assign deg_exp  = ph_sel == 3'h7 ? 9'h000
                    : ({6'h00, ph_sel} + 9'h001) * 9'h02d;
    // Counts how long the stage has been on, to bound the turn-on time
    assign on_cnt_d = buck_enable ? on_cnt_q + 16'h0001 : 16'h0000;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            on_cnt_q <= 16'h0000;
        else
            on_cnt_q <= on_cnt_d;
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_irq_sticky: assert property (
        !irq_out_n && !$past(hsel && hready && htrans[1] && hwrite)
        |=> !irq_out_n)
        else $error("interrupt pin released without a write");
    chk_volt_top: assert property (
        buck_cfg.buck_voltage_code >= 5'h1b |-> buck_mv_10 == 9'h19a)
        else $error("top codes do not give 4.10 V");
    chk_ilim_map: assert property (buck_ilim_da == ilim_exp)
        else $error("current limit decode wrong");
    chk_phase_map: assert property (buck_phase_deg == deg_exp)
        else $error("phase decode wrong");
    chk_stby_volt: assert property (
        $changed(standby_req) |-> $stable(buck_mv_10))
        else $error("voltage moved on standby change");
    chk_code_disch: assert property (
        buck_power_good && $changed(buck_cfg.buck_voltage_code)
        |-> ##[0:2] buck_discharge)
        else $error("new code applied without discharge");
    chk_pwm_settle: assert property (
        buck_cfg.buck_mode_field == buck_ctrl_pkg::MODE_PWM &&
        $past(buck_cfg.buck_mode_field) == buck_ctrl_pkg::MODE_PFM
        |=> !mode_settled)
        else $error("mode settled too early after leaving PFM");
    chk_turn_on: assert property (
        $rose(buck_power_good) |-> on_cnt_q >= TON_CYCLES - 2)
        else $error("output good before turn-on time");
    chk_disch_hold: assert property (
        $rose(buck_ramping) && buck_discharge
        |-> (buck_discharge && !buck_enable) [*6])
        else $error("ramp-down cut short");
    chk_off_stops: assert property (
        buck_enable && $past(buck_enable)
        |-> buck_cfg.buck_mode_field != buck_ctrl_pkg::MODE_OFF)
        else $error("stage on in mode off");
endmodule : buck_ctrl_sva

bind low_voltage_buck_ctrl buck_ctrl_sva #(.TON_CYCLES(TON_CYCLES)) u_sva (
    .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .standby_req,
    .buck_enable, .buck_discharge, .buck_ramping, .buck_power_good,
    .mode_settled, .buck_cfg, .buck_phase_deg, .buck_ilim_da, .buck_mv_10,
    .irq_out_n
);

// *** verification/ahb_host.sv ***
`timescale 1ns/1ps
module ahb_host (
    input  wire logic        hclk,   // Bus clock
    input  wire logic        hready, // Slave ready
    input  wire logic [31:0] hrdata, // Read data
    output logic             hsel,   // Select
    output logic      [31:0] haddr,  // Address
    output logic      [1:0]  htrans, // Transfer type
    output logic             hwrite, // Write
    output logic      [2:0]  hsize,  // Size
    output logic      [31:0] hwdata  // Write data
);
    int stalls;

    initial begin
        stalls = 0;
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h2;
        hwdata = 32'h0;
    end

    // ==========================================================
    // Single word transfers; a stuck slave is counted, not waited out
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1)
            stalls++;
    endtask : wait_ready

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer
endmodule : ahb_host

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [4:0] code;
        logic [1:0] ilim;
        logic [2:0] ph;
        logic [8:0] mv;
        logic [9:0] ia;
        logic [8:0] deg;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{5'h00, 2'h0, 3'h0, 9'h064, 10'h015, 9'h02d},
        '{5'h08, 2'h1, 3'h1, 9'h0b4, 10'h01a, 9'h05a},
        '{5'h11, 2'h2, 3'h2, 9'h118, 10'h01e, 9'h087},
        '{5'h1a, 2'h3, 3'h3, 9'h190, 10'h02d, 9'h0b4},
        '{5'h1b, 2'h0, 3'h4, 9'h19a, 10'h015, 9'h0e1},
        '{5'h1f, 2'h1, 3'h5, 9'h19a, 10'h01a, 9'h10e},
        '{5'h12, 2'h2, 3'h6, 9'h13b, 10'h01e, 9'h13b},
        '{5'h03, 2'h3, 3'h7, 9'h07d, 10'h02d, 9'h000}};
    logic                     hclk;
    logic                     hresetn;
    logic                     hsel;
    logic [31:0]              haddr;
    logic [1:0]               htrans;
    logic                     hwrite;
    logic [2:0]               hsize;
    logic [31:0]              hwdata;
    logic [31:0]              hrdata;
    logic                     hreadyout;
    logic [4:0]               otp_code;
    logic [1:0]               otp_ind;
    logic                     otp_seq;
    logic                     standby_req;
    logic                     buck_enable;
    logic                     buck_discharge;
    logic                     power_good;
    logic                     mode_settled;
    buck_ctrl_pkg::buck_cfg_t buck_cfg;
    logic [8:0]               deg;
    logic [9:0]               ilim;
    logic [8:0]               mv;
    logic                     ind_bad;
    logic                     irq_out_n;
    logic [31:0]              d;
    int                       fails;
    int                       checks;

    low_voltage_buck_ctrl #(.PFM_PWM_CYCLES(4), .RAMP_CYCLES(8),
                            .TON_CYCLES(16)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .otp_buck_voltage_default(otp_code),
        .otp_inductor_sel(otp_ind), .otp_in_powerup_seq(otp_seq),
        .standby_req(standby_req), .buck_enable(buck_enable),
        .buck_discharge(buck_discharge), .buck_ramping(),
        .buck_power_good(power_good), .mode_settled(mode_settled),
        .buck_cfg(buck_cfg), .buck_phase_deg(deg), .buck_ilim_da(ilim),
        .buck_mv_10(mv), .inductor_sel_invalid(ind_bad),
        .irq_out_n(irq_out_n));
    ahb_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    always #25 hclk = ~hclk;

    // ==========================================================
    // Helpers
    task automatic chk(input string n, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        host.xfer(1'b1, a, v, x);
    endtask : wr
    task automatic rdc(input string n, input logic [7:0] a, logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, d);
        chk(n, d, e);
    endtask : rdc
    // Ports are read a few edges after a write so its effects have landed
    task automatic settle();
        repeat (3) @(posedge hclk);
    endtask : settle
    task automatic wait_for(input logic dis, input logic v);
        int n;
        n = 0;
        while ((dis ? buck_discharge : power_good) !== v) begin
            @(posedge hclk);
            n++;
            if (n > 200) begin
                fails++;
                test_done();
            end
        end
    endtask : wait_for
    task automatic test_done();
        fails = fails + host.stalls;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge hclk);
        fails++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        fails = 0;
        checks = 0;
        hclk = 1'b0;
        hresetn = 1'b0;
        otp_code = 5'h08;
        otp_ind = 2'h3;
        otp_seq = 1'b1;
        standby_req = 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("phase_rst", {23'h0, deg}, 32'h0);
        chk("ind_bad", {31'h0, ind_bad}, 32'h1);
        rdc("code_rst", buck_ctrl_pkg::OFF_CTRL, 32'h8);
        rdc("mode_rst", buck_ctrl_pkg::OFF_MODE, 32'hf);
        wait_for(1'b0, 1'b1);
        chk("mv", {23'h0, mv}, 32'hb4);
        wr(buck_ctrl_pkg::OFF_IRQ, 32'h3);
        wr(buck_ctrl_pkg::OFF_MASK, 32'h0);
        wr(buck_ctrl_pkg::OFF_MODE, 32'ha);
        settle();
        chk("irq_pin", {31'h0, irq_out_n}, 32'h0);
        wr(buck_ctrl_pkg::OFF_MASK, 32'h1);
        settle();
        chk("irq_mask", {31'h0, irq_out_n}, 32'h1);
        rdc("irq_flag", buck_ctrl_pkg::OFF_IRQ, 32'h1);
        wr(buck_ctrl_pkg::OFF_IRQ, 32'h1);
        rdc("irq_clr", buck_ctrl_pkg::OFF_IRQ, 32'h0);
        wr(buck_ctrl_pkg::OFF_MASK, 32'h0);
        wr(buck_ctrl_pkg::OFF_MODE, 32'h9);
        repeat (2) @(posedge hclk);
        chk("settling", {31'h0, mode_settled}, 32'h0);
        repeat (10) @(posedge hclk);
        chk("settled", {31'h0, mode_settled}, 32'h1);
        chk("irq_pwm", {31'h0, irq_out_n}, 32'h0);
        wr(buck_ctrl_pkg::OFF_IRQ, 32'h3);
        standby_req <= 1'b1;
        settle();
        chk("stby_pg", {31'h0, power_good}, 32'h1);
        chk("stby_mode", {30'h0, buck_cfg.buck_mode_field}, 32'h2);
        wr(buck_ctrl_pkg::OFF_MODE, 32'h1);
        wait_for(1'b1, 1'b1);
        settle();
        chk("stby_off", {30'h0, buck_cfg.buck_mode_field}, 32'h0);
        standby_req <= 1'b0;
        wait_for(1'b0, 1'b1);
        chk("run_pwm", {30'h0, buck_cfg.buck_mode_field}, 32'h1);
        wr(buck_ctrl_pkg::OFF_CTRL, 32'h1b);
        wait_for(1'b1, 1'b1);
        wait_for(1'b0, 1'b1);
        chk("mv_new", {23'h0, mv}, 32'h19a);
        wr(8'h1c, 32'hffffffff);
        rdc("unmapped", 8'h1c, 32'h0);
        rdc("code_kept", buck_ctrl_pkg::OFF_CTRL, 32'h1b);
        wr(buck_ctrl_pkg::OFF_MODE, 32'h0);
        wait_for(1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            wr(buck_ctrl_pkg::OFF_CTRL, {27'h0, ROWS[i].code});
            wr(buck_ctrl_pkg::OFF_CFG, {27'h0, ROWS[i].ph, ROWS[i].ilim});
            rdc("mvolt", buck_ctrl_pkg::OFF_MVOLT, {23'h0, ROWS[i].mv});
            chk("mv_port", {23'h0, mv}, {23'h0, ROWS[i].mv});
            chk("ilim", {22'h0, ilim}, {22'h0, ROWS[i].ia});
            chk("deg", {23'h0, deg}, {23'h0, ROWS[i].deg});
        end
        hresetn <= 1'b0;
        otp_seq <= 1'b0;
        otp_code <= 5'h1f;
        otp_ind <= 2'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rdc("mode_off", buck_ctrl_pkg::OFF_MODE, 32'h0);
        rdc("code_otp", buck_ctrl_pkg::OFF_CTRL, 32'h1f);
        chk("ind_ok", {31'h0, ind_bad}, 32'h0);
        repeat (20) @(posedge hclk);
        chk("stays_off", {31'h0, buck_enable}, 32'h0);
        test_done();
    end
endmodule : tb_top
